// [logic/pfa_core.sv]
// program counter, return stack, paging and indirect data addressing
//
// What this block does
// RL1: 13-bit counter, low byte read/write, upper hidden
// RL2: any reset clears upper counter bits
// RL3: low-byte write loads upper bits from latch 4:0
// RL4: call/jump: 11 bits from instruction, page latch
// RL5: eight-entry 13-bit stack, pointer not accessible
// RL6: push on call and interrupt vector
// RL7: pop on any return instruction
// RL8: push and pop leave latch unchanged
// RL9: stack is circular, ninth push overwrites first
// RL10: no overflow or underflow indication
// RL11: return restores full counter from stack
// RL12: 8K space in four 2K pages
// RL13: single-page software keeps page bits zero
// RL14: computed jumps get no carry into upper bits
// RL15: indirect port accesses register at pointer
// RL16: pointer zero indirect read returns zero
// RL17: pointer zero indirect write changes nothing
// RL18: indirect address is bank bit over pointer
// RL19: stack pointer wraps modulo eight on pop
`include "pfa_defs.svh"
module pfa_core (
    input  wire logic                     clk_in,
    input  wire logic                     reset_in,
    input  wire pfa_pkg::pfa_flow_t       flow_in,
    input  wire pfa_pkg::pfa_file_t       file_in,
    input  wire logic [`PFA_LOW_W-1:0]    file_select_pointer_in,
    input  wire logic [`PFA_LOW_W-1:0]    status_in,
    input  wire logic [`PFA_LOW_W-1:0]    mem_rdata_in,
    output logic [`PFA_PC_W-1:0]          pc_out,
    output logic [`PFA_LOW_W-1:0]         counter_low_byte_out,
    output logic [`PFA_LOW_W-1:0]         counter_high_latch_out,
    output pfa_pkg::pfa_mem_t             mem_out,
    output logic [`PFA_LOW_W-1:0]         file_rdata_out
);
    import pfa_pkg::*;

    logic [`PFA_PC_W-1:0]    pc;
    logic [`PFA_LOW_W-1:0]   counter_high_latch;
    logic [`PFA_PC_W-1:0]    stack [`PFA_STACK_DEPTH];
    logic [`PFA_SP_W-1:0]    sp;
    logic [`PFA_PC_W-1:0]    next_pc;
    logic [`PFA_PC_W-1:0]    return_addr;
    logic                    port_hit;
    logic                    low_write;
    logic                    latch_write;
    logic                    do_push;
    logic                    do_pop;

    // the low byte and latch are claimed by their file addresses; they
    // are given as parameters since this block only sees the bus
    localparam logic [`PFA_LOW_W-1:0] LOW_ADDR   = `PFA_LOW_ADDR;
    localparam logic [`PFA_LOW_W-1:0] LATCH_ADDR = `PFA_LATCH_ADDR;

    function automatic logic [`PFA_SP_W-1:0] sp_step(
        input logic [`PFA_SP_W-1:0] value,
        input logic                 up
    );
        // natural 3-bit overflow gives the modulo-eight wrap
        sp_step = up ? value + `PFA_SP_ONE : value - `PFA_SP_ONE;
    endfunction

    function automatic logic [`PFA_PC_W-1:0] page_target(
        input logic [`PFA_LOW_W-1:0]  latch,
        input logic [`PFA_JUMP_W-1:0] target
    );
        page_target = {latch[`PFA_PAGE_HI:`PFA_PAGE_LO], target}; // [RL4]
    endfunction

    assign port_hit    = (file_in.addr == `PFA_PORT_ADDR);
    assign low_write   = file_in.write && (file_in.addr == LOW_ADDR);
    assign latch_write = file_in.write && (file_in.addr == LATCH_ADDR);
    assign do_push     = (flow_in.op == PFA_OP_CALL) ||
                         (flow_in.op == PFA_OP_VECTOR); // [RL6]
    assign do_pop      = (flow_in.op == PFA_OP_RETURN); // [RL7]
    assign return_addr = stack[sp_step(sp, 1'b0)];
    assign pc_out                 = pc;
    assign counter_low_byte_out   = pc[`PFA_LOW_W-1:0];
    assign counter_high_latch_out = counter_high_latch;

    // one source per cycle: the op decides, and a low-byte write only
    // counts when no branch is in flight, so a branch always wins over
    // a computed jump issued in the same cycle
    always_comb begin
        next_pc = pc;
        if (flow_in.advance) begin
            next_pc = pc + `PFA_PC_ONE;
        end
        unique case (flow_in.op)
            PFA_OP_NONE: begin
                if (low_write) begin
                    // no carry from the low byte reaches the top [RL14]
                    next_pc = {counter_high_latch[`PFA_UPPER_W-1:0],
                               file_in.wdata}; // [RL3] [RL1]
                end
            end
            PFA_OP_JUMP, PFA_OP_CALL: begin
                next_pc = page_target(counter_high_latch,
                                      flow_in.target); // [RL4] [RL12]
            end
            PFA_OP_RETURN: begin
                next_pc = return_addr; // [RL11]
            end
            PFA_OP_VECTOR: begin
                next_pc = flow_in.vector;
            end
            default: begin
                next_pc = pc;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            pc <= `PFA_RESET_PC; // [RL2]
        end else begin
            pc <= next_pc;
        end
    end

    // the latch is touched only by reset and file writes, never by stack traffic
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            counter_high_latch <= `PFA_RESET_LATCH;
        end else if (latch_write) begin
            counter_high_latch <= file_in.wdata; // [RL8]
        end
    end

    // stack has no flags and no file address at all
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            sp <= `PFA_RESET_SP;
        end else if (do_push) begin
            sp <= sp_step(sp, 1'b1); // [RL9] [RL10]
        end else if (do_pop) begin
            sp <= sp_step(sp, 1'b0); // [RL19]
        end
    end

    // pushed value is the return address, i.e. the next instruction
    always_ff @(posedge clk_in) begin
        if (do_push && !reset_in) begin
            stack[sp] <= pc + `PFA_PC_ONE; // [RL5] [RL9]
        end
    end

    // the indirect port holds no storage: it is steered onto the data
    // bus at the pointer; pointer zero would address the port itself,
    // so that access is dropped rather than looping back
    always_comb begin
        mem_out.addr  = {status_in[`PFA_BANK_BIT],
                         file_select_pointer_in}; // [RL18]
        mem_out.wdata = file_in.wdata;
        mem_out.read  = 1'b0;
        mem_out.write = 1'b0;
        if (port_hit) begin
            if (file_select_pointer_in != `PFA_ZERO_PTR) begin
                mem_out.read  = file_in.read; // [RL15]
                mem_out.write = file_in.write; // [RL17]
            end
        end else begin
            mem_out.addr  = {status_in[`PFA_BANK_BIT], file_in.addr};
            mem_out.read  = file_in.read && !low_write;
            mem_out.write = file_in.write && !low_write && !latch_write;
        end
    end

    // read data is registered, so it trails the request by one cycle;
    // the core's own bytes are served here and not from memory
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            file_rdata_out <= `PFA_ZERO_READ;
        end else if (port_hit &&
                     file_select_pointer_in == `PFA_ZERO_PTR) begin
            file_rdata_out <= `PFA_ZERO_READ; // [RL16]
        end else if (!port_hit && file_in.addr == LOW_ADDR) begin
            file_rdata_out <= pc[`PFA_LOW_W-1:0]; // [RL1]
        end else if (!port_hit && file_in.addr == LATCH_ADDR) begin
            file_rdata_out <= counter_high_latch;
        end else begin
            file_rdata_out <= mem_rdata_in;
        end
    end

    // sequences shared by the stack properties
    sequence s_call;
        flow_in.op == PFA_OP_CALL;
    endsequence
    sequence s_ret;
        flow_in.op == PFA_OP_RETURN;
    endsequence
    sequence s_push;
        do_push;
    endsequence
    sequence s_pop;
        do_pop && !do_push;
    endsequence
    sequence s_idle_stack;
        !do_push && !do_pop;
    endsequence

    // counter loading
    a_reset_clears: assert property (@(posedge clk_in) // [RL2]
        reset_in |=> pc_out == `PFA_RESET_PC)
        else $error("counter not cleared by reset");

    a_reset_latch: assert property (@(posedge clk_in) // [RL2]
        reset_in |=> counter_high_latch_out == `PFA_RESET_LATCH)
        else $error("latch not cleared by reset");

    a_reset_rdata: assert property (@(posedge clk_in) // [RL2]
        reset_in |=> file_rdata_out == `PFA_ZERO_READ)
        else $error("read data not cleared by reset");

    a_low_write_load: assert property (@(posedge clk_in) // [RL3]
        disable iff (reset_in)
        (flow_in.op == PFA_OP_NONE && low_write) |=>
        pc_out == {$past(counter_high_latch[`PFA_UPPER_W-1:0]),
                   $past(file_in.wdata)})
        else $error("low byte write did not load latch bits");

    a_low_byte_view: assert property (@(posedge clk_in) // [RL1]
        counter_low_byte_out == pc_out[`PFA_LOW_W-1:0])
        else $error("low byte output differs from counter");

    a_low_read_back: assert property (@(posedge clk_in) // [RL1]
        disable iff (reset_in)
        (!port_hit && file_in.addr == LOW_ADDR) |=>
        file_rdata_out == $past(pc_out[`PFA_LOW_W-1:0]))
        else $error("low byte read back wrong");

    a_latch_read_back: assert property (@(posedge clk_in) // [RL3]
        disable iff (reset_in)
        (!port_hit && file_in.addr == LATCH_ADDR) |=>
        file_rdata_out == $past(counter_high_latch_out))
        else $error("latch read back wrong");

    a_advance_step: assert property (@(posedge clk_in) // [RL1]
        disable iff (reset_in)
        (flow_in.op == PFA_OP_NONE && flow_in.advance && !low_write) |=>
        pc_out == $past(pc_out) + `PFA_PC_ONE)
        else $error("counter did not advance");

    a_latch_load: assert property (@(posedge clk_in) // [RL3]
        disable iff (reset_in)
        latch_write |=> counter_high_latch_out == $past(file_in.wdata))
        else $error("latch write lost");

    a_jump_page: assert property (@(posedge clk_in) // [RL4]
        disable iff (reset_in)
        (flow_in.op == PFA_OP_JUMP) |=>
        pc_out == {$past(counter_high_latch[`PFA_PAGE_HI:`PFA_PAGE_LO]),
                   $past(flow_in.target)})
        else $error("jump target wrong");

    a_call_page: assert property (@(posedge clk_in) // [RL12]
        disable iff (reset_in)
        s_call |=>
        pc_out[`PFA_JUMP_W-1:0] == $past(flow_in.target))
        else $error("call left its page offset wrong");

    // return stack
    a_call_return: assert property (@(posedge clk_in) // [RL11]
        disable iff (reset_in)
        (s_call ##1 s_ret) |=> pc_out == $past(pc_out, 2) + `PFA_PC_ONE)
        else $error("return did not restore call address");

    a_return_pop: assert property (@(posedge clk_in) // [RL11]
        disable iff (reset_in)
        s_ret |=> pc_out == $past(return_addr))
        else $error("return did not take stack top");

    a_vector_load: assert property (@(posedge clk_in) // [RL6]
        disable iff (reset_in)
        (flow_in.op == PFA_OP_VECTOR) |=> pc_out == $past(flow_in.vector))
        else $error("vector not loaded");

    a_push_moves: assert property (@(posedge clk_in) // [RL6]
        disable iff (reset_in)
        s_push |=> sp == $past(sp) + `PFA_SP_ONE)
        else $error("push did not advance pointer");

    a_push_stores: assert property (@(posedge clk_in) // [RL5]
        disable iff (reset_in)
        s_push |=> stack[$past(sp)] == $past(pc_out) + `PFA_PC_ONE)
        else $error("push stored wrong return address");

    a_push_wraps: assert property (@(posedge clk_in) // [RL9]
        disable iff (reset_in)
        (do_push && sp == `PFA_SP_LAST) |=> sp == `PFA_RESET_SP)
        else $error("ninth push did not reuse first entry");

    a_pop_moves: assert property (@(posedge clk_in) // [RL19]
        disable iff (reset_in)
        s_pop |=> sp == $past(sp) - `PFA_SP_ONE)
        else $error("pop did not retreat pointer");

    a_pop_wraps: assert property (@(posedge clk_in) // [RL19]
        disable iff (reset_in)
        (do_pop && sp == `PFA_RESET_SP) |=> sp == `PFA_SP_LAST)
        else $error("pop below bottom did not wrap");

    a_stack_quiet: assert property (@(posedge clk_in) // [RL10]
        disable iff (reset_in)
        s_idle_stack |=> $stable(sp))
        else $error("pointer moved without stack traffic");

    a_latch_stable: assert property (@(posedge clk_in) // [RL8]
        disable iff (reset_in)
        ((do_push || do_pop) && !latch_write) |=>
        $stable(counter_high_latch_out))
        else $error("stack traffic changed latch");

    // indirect and direct data access
    a_zero_ptr_read: assert property (@(posedge clk_in) // [RL16]
        disable iff (reset_in)
        (port_hit && file_select_pointer_in == `PFA_ZERO_PTR) |=>
        file_rdata_out == `PFA_ZERO_READ)
        else $error("pointer zero read not zero");

    a_zero_ptr_write: assert property (@(posedge clk_in) // [RL17]
        (port_hit && file_select_pointer_in == `PFA_ZERO_PTR) |->
        !mem_out.write && !mem_out.read)
        else $error("pointer zero access reached memory");

    a_indirect_addr: assert property (@(posedge clk_in) // [RL15] [RL18]
        (port_hit && file_select_pointer_in != `PFA_ZERO_PTR) |->
        mem_out.addr == {status_in[`PFA_BANK_BIT],
                         file_select_pointer_in} &&
        mem_out.write == file_in.write)
        else $error("indirect address wrong");

    a_direct_addr: assert property (@(posedge clk_in) // [RL18]
        !port_hit |->
        mem_out.addr == {status_in[`PFA_BANK_BIT], file_in.addr})
        else $error("direct address wrong");

    a_direct_reads: assert property (@(posedge clk_in) // [RL15]
        (!port_hit && file_in.addr != LOW_ADDR &&
         file_in.addr != LATCH_ADDR) |-> mem_out.read == file_in.read)
        else $error("direct read not passed to memory");

    a_regs_private: assert property (@(posedge clk_in) // [RL1]
        (low_write || latch_write) |-> !mem_out.write)
        else $error("counter register write leaked to memory");
endmodule

// [logic/pfa_defs.svh]
// constants for the program flow and indirect addressing block
`ifndef PFA_DEFS_SVH
`define PFA_DEFS_SVH
`define PFA_PC_W        13
`define PFA_UPPER_W     5
`define PFA_LOW_W       8
`define PFA_JUMP_W      11
`define PFA_PAGE_W      2
`define PFA_PAGE_HI     4
`define PFA_PAGE_LO     3
`define PFA_STACK_DEPTH 8
`define PFA_SP_W        3
`define PFA_DADDR_W     9
`define PFA_BANK_BIT    7
`define PFA_PORT_ADDR   8'h00
`define PFA_ZERO_PTR    8'h00
`define PFA_ZERO_READ   8'h00
`define PFA_RESET_PC    13'h0000
`define PFA_RESET_LOW   8'h00
`define PFA_RESET_LATCH 8'h00
`define PFA_RESET_SP    3'h0
`define PFA_SP_ONE      3'h1
`define PFA_PC_ONE      13'h0001
`define PFA_SP_LAST     3'h7
`define PFA_LOW_ADDR    8'h02
`define PFA_LATCH_ADDR  8'h0A
`endif

// [logic/pfa_pkg.sv]
// types shared by the program flow and indirect addressing block
`include "pfa_defs.svh"
package pfa_pkg;
    typedef enum logic [4:0] {
        PFA_OP_NONE   = 5'h01,
        PFA_OP_JUMP   = 5'h02,
        PFA_OP_CALL   = 5'h04,
        PFA_OP_RETURN = 5'h08,
        PFA_OP_VECTOR = 5'h10
    } pfa_op_t;

    typedef struct packed {
        pfa_op_t                   op;
        logic [`PFA_JUMP_W-1:0]    target;
        logic [`PFA_PC_W-1:0]      vector;
        logic                      advance;
    } pfa_flow_t;

    typedef struct packed {
        logic                      read;
        logic                      write;
        logic [`PFA_LOW_W-1:0]     addr;
        logic [`PFA_LOW_W-1:0]     wdata;
    } pfa_file_t;

    typedef struct packed {
        logic                      read;
        logic                      write;
        logic [`PFA_DADDR_W-1:0]   addr;
        logic [`PFA_LOW_W-1:0]     wdata;
    } pfa_mem_t;
endpackage

// [verif/pfa_mem_model.sv]
// data memory partner answering the core's memory accesses
`include "pfa_defs.svh"
module pfa_mem_model import pfa_pkg::*; (
    input  wire logic              clk_in,
    input  wire pfa_pkg::pfa_mem_t mem_in,
    output logic [7:0]             rdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] ram [0:511];
    logic [7:0] last;
    always_ff @(posedge clk_in) begin
        if (mem_in.write) begin
            ram[mem_in.addr] <= mem_in.wdata;
        end
        if (mem_in.read) begin
            last <= ram[mem_in.addr];
        end
    end
    // idle bus shows the inverse of the last read, so stale data never matches
    assign rdata_out = mem_in.read ? ram[mem_in.addr] : ~last;
endmodule

// [verif/program_flow_and_indirect_addressing_test.sv]
// testbench for the program flow and indirect addressing core
module program_flow_and_indirect_addressing_test import pfa_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_in;
    logic        reset_in;
    pfa_flow_t   flow_in;
    pfa_file_t   file_in;
    logic [7:0]  ptr;
    logic [7:0]  status;
    logic [7:0]  mem_rdata;
    logic [12:0] pc;
    logic [7:0]  low_byte;
    logic [7:0]  latch;
    pfa_mem_t    mem;
    logic [7:0]  file_rdata;
    int          err_count;
    int          check_count;
    // latch value, jump target, expected counter
    localparam logic [31:0] ROWS [3] = '{{8'h18, 11'h7FF, 13'h1FFF},
        {8'h07, 11'h123, 13'h0123}, {8'h08, 11'h400, 13'h0C00}};

    pfa_core u_pfa_core (.clk_in(clk_in), .reset_in(reset_in),
        .flow_in(flow_in), .file_in(file_in),
        .file_select_pointer_in(ptr), .status_in(status),
        .mem_rdata_in(mem_rdata), .pc_out(pc),
        .counter_low_byte_out(low_byte), .counter_high_latch_out(latch),
        .mem_out(mem), .file_rdata_out(file_rdata));
    pfa_mem_model u_pfa_mem_model (.clk_in(clk_in), .mem_in(mem),
        .rdata_out(mem_rdata));

    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic flow(input pfa_op_t op, input logic [10:0] tgt,
                        input logic [12:0] vec);
        flow_in = '{op, tgt, vec, 1'b0};
        cyc(1);
        flow_in.op = PFA_OP_NONE;
    endtask
    task automatic fwr(input logic [7:0] a, input logic [7:0] d);
        file_in = '{1'b0, 1'b1, a, d};
        cyc(1);
        file_in = '0;
    endtask
    task automatic frd(input logic [7:0] a);
        file_in = '{1'b1, 1'b0, a, 8'h00};
        cyc(1);
        file_in = '0;
    endtask
    // indirect access: checks the memory strobe and, when enabled, address
    task automatic ind(input logic wr, input logic [7:0] d,
                       input logic [12:0] addr, input logic en);
        file_in = '{~wr, wr, 8'h00, d};
        #1;
        chk({12'h0, wr ? mem.write : mem.read}, {12'h0, en});
        if (en) chk({4'h0, mem.addr}, addr);
        cyc(1);
        file_in = '0;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        #100000;
        err_count++;
        tally_and_finish();
    end

    initial begin
        flow_in = '{PFA_OP_NONE, 11'h000, 13'h0000, 1'b0};
        file_in = '0;
        ptr = 8'h00;
        status = 8'h00;
        err_count = 0;
        check_count = 0;
        reset_in = 1'b1;
        cyc(4);
        reset_in = 1'b0;
        chk(pc, 13'h0000);
        chk({5'h0, latch}, 13'h0000);
        $display("reset test done");
        foreach (ROWS[i]) begin
            fwr(8'h0A, ROWS[i][31:24]);
            flow(PFA_OP_JUMP, ROWS[i][23:13], 13'h0000);
            chk(pc, ROWS[i][12:0]);
        end
        $display("jump rows done");
        fwr(8'h0A, 8'h15);
        fwr(8'h02, 8'h34);
        chk(pc, 13'h1534);
        frd(8'h02);
        chk({5'h0, file_rdata}, 13'h0034);
        chk({5'h0, low_byte}, 13'h0034);
        flow_in.advance = 1'b1;
        cyc(2);
        flow_in.advance = 1'b0;
        chk(pc, 13'h1536);
        $display("low byte test done");
        fwr(8'h0A, 8'h00);
        flow(PFA_OP_JUMP, 11'h100, 13'h0000);
        for (int n = 0; n < 10; n++) flow(PFA_OP_CALL, 11'(32'h200 + n), 0);
        fwr(8'h0A, 8'h1F);
        for (int k = 0; k < 9; k++) begin
            flow(PFA_OP_RETURN, 11'h000, 13'h0000);
            chk(pc, 13'h0209 - 13'(k % 8));
            chk({5'h0, latch}, 13'h001F);
        end
        $display("stack wrap test done");
        fwr(8'h0A, 8'h00);
        flow(PFA_OP_JUMP, 11'h050, 13'h0000);
        flow(PFA_OP_VECTOR, 11'h000, 13'h0004);
        chk(pc, 13'h0004);
        flow(PFA_OP_RETURN, 11'h000, 13'h0000);
        chk(pc, 13'h0051);
        $display("vector test done");
        ptr = 8'h40;
        status = 8'h80;
        ind(1'b1, 8'h5A, 13'h0140, 1'b1);
        frd(8'h00);
        chk({5'h0, file_rdata}, 13'h005A);
        status = 8'h00;
        ind(1'b0, 8'h00, 13'h0040, 1'b1);
        ptr = 8'h00;
        status = 8'h80;
        ind(1'b1, 8'hFF, 13'h0000, 1'b0);
        frd(8'h00);
        chk({5'h0, file_rdata}, 13'h0000);
        $display("indirect test done");
        flow(PFA_OP_JUMP, 11'h3FF, 13'h0000);
        fwr(8'h0A, 8'h18);
        reset_in = 1'b1;
        cyc(1);
        reset_in = 1'b0;
        chk(pc, 13'h0000);
        chk({5'h0, latch}, 13'h0000);
        $display("mid-run reset test done");
        tally_and_finish();
    end
endmodule
